// ---- design/asr_defines.vh ----
// Constants for the addressable shift register: limits, register map,
// field positions and reset values.
// Assumes inclusion by its bare name from every design file that needs it.
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH

`define ASR_DATA_W      16
`define ASR_ADDR_W      10
`define ASR_DEPTH_MIN   11'h002
`define ASR_DEPTH_MAX   11'h400
`define ASR_DATA_W_MAX  255
`define ASR_LAT_W       11

`define ASR_INIT_MAX    4
`define ASR_INIT_LEN    4
`define ASR_INIT_VEC    64'h0004_0003_0002_0001

`define ASR_OFF_CTRL    8'h00
`define ASR_OFF_LAT     8'h04
`define ASR_OFF_STATUS  8'h08
`define ASR_OFF_COUNT   8'h0C
`define ASR_OFF_LAST    8'h10

`define ASR_CTRL_EN     0
`define ASR_CTRL_INFER  1
`define ASR_CTRL_SPEED  2
`define ASR_CTRL_REINIT 3
`define ASR_CTRL_CLRCNT 4

`define ASR_ST_OVALID   0
`define ASR_ST_IREADY   1
`define ASR_ST_STAGE    2
`define ASR_ST_CNT_LSB  4

`define ASR_CTRL_RST    3'h3
`define ASR_LAT_RST     11'h400

`endif

// ---- design/asr_chain.v ----
// Shift chain with a combinational tap multiplexer.
// Assumes the caller gives shift and reinit as single-cycle qualifiers.
`timescale 1ns/100ps
`include "asr_defines.vh"

module asr_chain #(
	parameter W  = `ASR_DATA_W,
	parameter AW = `ASR_ADDR_W
) (
	input  wire                 clock,
	input  wire                 rst_n,
	input  wire                 shift,
	input  wire                 reinit,
	input  wire [W-1:0]         d,
	input  wire [AW-1:0]        addr,
	input  wire [`ASR_LAT_W-1:0] depth,
	output wire [W-1:0]         tap
);
	localparam DEPTH = 1 << AW;
	localparam [W*`ASR_INIT_MAX-1:0] IV = `ASR_INIT_VEC;

	wire [W*DEPTH-1:0]     chain;
	wire [`ASR_LAT_W-1:0]  addr_x;
	wire [AW-1:0]          sel;

	// Taps past the configured depth read the last live register.
	assign addr_x = {{(`ASR_LAT_W-AW){1'b0}}, addr};
	assign sel    = (addr_x >= depth) ? depth[AW-1:0] - 1'b1 : addr;
	assign tap    = chain[sel*W +: W];

	genvar i;
	generate
		for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
			// Shifting keeps every select in range for stages past the vector.
			localparam [W*`ASR_INIT_MAX-1:0] IV_SH = IV >> (i*W);
			localparam [W-1:0] INIT = (i < `ASR_INIT_LEN) ?
				IV_SH[W-1:0] : {W{1'b0}};
			reg  [W-1:0] q_r;
			wire [W-1:0] src;
			if (i == 0) begin : g_head
				assign src = d;
			end else begin : g_body
				assign src = chain[(i-1)*W +: W];
			end
			always @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					q_r <= INIT;
				end else if (reinit) begin
					q_r <= INIT;
				end else if (shift) begin
					q_r <= src;
				end
			end
			assign chain[i*W +: W] = q_r;
		end
	endgenerate
endmodule // asr_chain

// ---- design/asr_buf.v ----
// Two-entry output buffer with registered valid, data and fill count.
// Assumes the writer pushes only while the count leaves room.
`timescale 1ns/100ps
`include "asr_defines.vh"

module asr_buf #(
	parameter W = `ASR_DATA_W
) (
	input  wire         clock,
	input  wire         rst_n,
	input  wire         in_valid,
	input  wire [W-1:0] in_data,
	input  wire         out_ready,
	output reg          out_valid,
	output reg  [W-1:0] out_data,
	output reg  [1:0]   count
);
	reg [W-1:0] spare_r;
	wire        pop;

	assign pop = out_valid & out_ready;

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			out_valid <= 1'b0;
			out_data  <= {W{1'b0}};
			spare_r   <= {W{1'b0}};
			count     <= 2'h0;
		end else begin
			case (count)
			2'h0: begin
				if (in_valid) begin
					out_data  <= in_data;
					out_valid <= 1'b1;
					count     <= 2'h1;
				end
			end
			2'h1: begin
				if (in_valid && pop) begin
					out_data <= in_data;
				end else if (in_valid) begin
					spare_r <= in_data;
					count   <= 2'h2;
				end else if (pop) begin
					out_valid <= 1'b0;
					count     <= 2'h0;
				end
			end
			default: begin
				if (pop) begin
					out_data <= spare_r;
					if (in_valid) begin
						spare_r <= in_data;
					end else begin
						count <= 2'h1;
					end
				end
			end
			endcase
		end
	end
endmodule // asr_buf

// ---- design/asr_top.v ----
// Addressable shift register with an APB register file and a buffered
// output stream.
// Assumes one clock, synchronous inputs and an APB master on the same clock.
`timescale 1ns/100ps
`include "asr_defines.vh"

module asr_top (
	input  wire                   clock,
	input  wire                   rst_n,
	input  wire [7:0]             paddr,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output reg                    pready,
	output reg                    pslverr,
	input  wire                   s_valid,
	output reg                    s_ready,
	input  wire [`ASR_DATA_W-1:0] s_data,
	input  wire [`ASR_ADDR_W-1:0] tap_addr,
	input  wire                   en,
	output wire                   m_valid,
	input  wire                   m_ready,
	output wire [`ASR_DATA_W-1:0] m_data
);
	localparam W  = `ASR_DATA_W;
	localparam AW = `ASR_ADDR_W;
	localparam LW = `ASR_LAT_W;
	localparam [2:0] CTRL_RST = `ASR_CTRL_RST;

	// The sample width is fixed inside the range the core form allows.
	localparam W_OK = (W >= 1) && (W <= `ASR_DATA_W_MAX);
	localparam A_OK = (AW >= 1) && (AW <= 10);

	// Control and status registers.
	reg               ctrl_en_r;
	reg               ctrl_infer_r;
	reg               ctrl_speed_r;
	reg               reinit_r;
	reg  [LW-1:0]     lat_r;
	reg  [31:0]       count_r;
	reg  [W-1:0]      last_r;

	// Speed pipeline stage between the multiplexer and the buffer.
	reg               stage_valid_r;
	reg  [W-1:0]      stage_data_r;

	wire [W-1:0]      tap;
	wire [1:0]        buf_count;
	wire              take;
	wire              stage_load;
	wire              buf_push;
	wire [W-1:0]      buf_data;
	wire              pop;
	wire [LW-1:0]     depth;
	wire [LW-1:0]     depth_inferred;

	// APB decode.
	wire              setup;
	wire              access;
	wire              wr;
	wire              hit_ctrl;
	wire              hit_lat;
	wire              hit_status;
	wire              hit_count;
	wire              hit_last;
	wire              mapped;
	wire              wr_ctrl;
	wire              wr_lat;
	wire [LW-1:0]     lat_wdata;
	wire [LW-1:0]     lat_clamped;
	wire              ctrl_en_nxt;
	wire              clr_cnt;

	reg  [31:0]       rd_value;
	reg  [2:0]        occ_nxt;
	reg  [1:0]        buf_count_nxt;
	reg               stage_valid_nxt;

	assign setup      = psel & ~penable;
	assign access     = psel & penable & pready;
	assign wr         = access & pwrite;
	assign hit_ctrl   = (paddr == `ASR_OFF_CTRL);
	assign hit_lat    = (paddr == `ASR_OFF_LAT);
	assign hit_status = (paddr == `ASR_OFF_STATUS);
	assign hit_count  = (paddr == `ASR_OFF_COUNT);
	assign hit_last   = (paddr == `ASR_OFF_LAST);
	assign mapped     = hit_ctrl | hit_lat | hit_status | hit_count |
	                    hit_last;
	assign wr_ctrl    = wr & hit_ctrl;
	assign wr_lat     = wr & hit_lat;
	assign clr_cnt    = wr_ctrl & pwdata[`ASR_CTRL_CLRCNT];
	assign ctrl_en_nxt = wr_ctrl ? pwdata[`ASR_CTRL_EN] : ctrl_en_r;

	// Out-of-range latency writes are pulled back to the nearest legal depth.
	assign lat_wdata   = (pwdata[31:LW] != {(32-LW){1'b0}}) ?
	                     `ASR_DEPTH_MAX : pwdata[LW-1:0];
	assign lat_clamped = (lat_wdata < `ASR_DEPTH_MIN) ? `ASR_DEPTH_MIN :
	                     (lat_wdata > `ASR_DEPTH_MAX) ? `ASR_DEPTH_MAX :
	                     lat_wdata;

	assign depth_inferred = `ASR_DEPTH_MAX >> (10 - AW);
	assign depth = ctrl_infer_r ? depth_inferred : lat_r;

	// A sample is taken only with the port enable high; otherwise the chain
	// holds and the offered sample waits.
	assign take = s_valid & s_ready & en & ctrl_en_r;

	// The tap is captured from the chain as it stands before this edge's
	// shift, so a sample never reaches the output in its own cycle.
	assign stage_load = take & (ctrl_speed_r | stage_valid_r);
	assign buf_push   = stage_valid_r | (take & ~stage_load);
	assign buf_data   = stage_valid_r ? stage_data_r : tap;
	assign pop        = m_valid & m_ready;

	asr_chain #(
		.W  (W),
		.AW (AW)
	) u_chain (
		.clock  (clock),
		.rst_n  (rst_n),
		.shift  (take & ~reinit_r),
		.reinit (reinit_r),
		.d      (s_data),
		.addr   (tap_addr),
		.depth  (depth),
		.tap    (tap)
	);

	asr_buf #(
		.W (W)
	) u_buf (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (buf_push),
		.in_data   (buf_data),
		.out_ready (m_ready),
		.out_valid (m_valid),
		.out_data  (m_data),
		.count     (buf_count)
	);

	// Next occupancy of stage and buffer decides the registered ready, so
	// a word taken next cycle always has a place to land.
	always @* begin
		buf_count_nxt = buf_count;
		if (buf_push && !pop) begin
			buf_count_nxt = buf_count + 2'h1;
		end else if (!buf_push && pop) begin
			buf_count_nxt = buf_count - 2'h1;
		end
		stage_valid_nxt = stage_load;
		occ_nxt = {1'b0, buf_count_nxt} + {2'h0, stage_valid_nxt};
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_ready <= 1'b0;
		end else begin
			s_ready <= ctrl_en_nxt & (occ_nxt <= 3'h1);
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage_valid_r <= 1'b0;
			stage_data_r  <= {W{1'b0}};
		end else begin
			stage_valid_r <= stage_valid_nxt;
			if (stage_load) begin
				stage_data_r <= tap;
			end
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			last_r <= {W{1'b0}};
		end else if (buf_push) begin
			last_r <= buf_data;
		end
	end

	// The count keeps a sample taken in the clearing cycle.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= 32'h0000_0000;
		end else if (clr_cnt) begin
			count_r <= take ? 32'h0000_0001 : 32'h0000_0000;
		end else if (take) begin
			count_r <= count_r + 32'h0000_0001;
		end
	end

	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_en_r    <= CTRL_RST[`ASR_CTRL_EN];
			ctrl_infer_r <= CTRL_RST[`ASR_CTRL_INFER];
			ctrl_speed_r <= CTRL_RST[`ASR_CTRL_SPEED];
			reinit_r     <= 1'b0;
			lat_r        <= `ASR_LAT_RST;
		end else begin
			reinit_r <= wr_ctrl & pwdata[`ASR_CTRL_REINIT];
			if (wr_ctrl) begin
				ctrl_en_r    <= pwdata[`ASR_CTRL_EN];
				ctrl_infer_r <= pwdata[`ASR_CTRL_INFER];
				ctrl_speed_r <= pwdata[`ASR_CTRL_SPEED];
			end
			if (wr_lat) begin
				lat_r <= lat_clamped;
			end
		end
	end

	always @* begin
		rd_value = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_value[`ASR_CTRL_EN]    = ctrl_en_r;
			rd_value[`ASR_CTRL_INFER] = ctrl_infer_r;
			rd_value[`ASR_CTRL_SPEED] = ctrl_speed_r;
		end else if (hit_lat) begin
			rd_value[LW-1:0] = lat_r;
		end else if (hit_status) begin
			rd_value[`ASR_ST_OVALID] = m_valid;
			rd_value[`ASR_ST_IREADY] = s_ready;
			rd_value[`ASR_ST_STAGE]  = stage_valid_r;
			rd_value[`ASR_ST_CNT_LSB +: 2] = buf_count;
		end else if (hit_count) begin
			rd_value = count_r;
		end else if (hit_last) begin
			rd_value[W-1:0] = last_r;
		end
	end

	// One wait-free access phase: the answer is prepared in the setup cycle.
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= ~mapped;
				prdata  <= pwrite ? 32'h0000_0000 : rd_value;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end
endmodule // asr_top

// ---- dv/asr_top_checker.sv ----
// Checker on asr_top ports: APB answer timing, output hold, enable.
// Assumes one clock and the active-low reset of the top.
`timescale 1ns/100ps
module asr_top_checker (
	input logic		clock,
	input logic		rst_n,
	input logic [7:0]	paddr,
	input logic		psel,
	input logic		penable,
	input logic		pready,
	input logic		pslverr,
	input logic		s_ready,
	input logic		en,
	input logic		m_valid,
	input logic		m_ready,
	input logic [15:0]	m_data
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_apb_answer: assert property (s_setup |=> s_access)
		else $error("no access cycle after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property
		(psel && !penable && paddr > 8'h10 |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && !penable && paddr <= 8'h10
		&& paddr[1:0] == 2'h0 |=> !pslverr)
		else $error("mapped access refused");
	a_out_hold: assert property
		(m_valid && !m_ready |=> m_valid && $stable(m_data))
		else $error("output word changed while stalled");
	a_en_ready: assert property (!en && s_ready |=> s_ready)
		else $error("s_ready dropped with enable low");
	a_en_freeze: assert property (!en [*2] |=> !$rose(m_valid))
		else $error("output appeared with enable low");
endmodule // asr_top_checker

bind asr_top asr_top_checker u_chk (
	.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr),
	.s_ready(s_ready), .en(en), .m_valid(m_valid),
	.m_ready(m_ready), .m_data(m_data)
);

// ---- dv/asr_stream_model.sv ----
// Datapath neighbour: random sample source with tap and enable, and a
// sink that may stall; each word taken by the sink is reported.
// Assumes the bench drives act, stall and tap_mod on the same clock.
`timescale 1ns/100ps
module asr_stream_model (
	input logic		clock,
	input logic		rst_n,
	input logic		act,
	input logic		stall,
	input logic [10:0]	tap_mod,
	input logic		s_ready,
	input logic		m_valid,
	input logic [15:0]	m_data,
	output logic		s_valid,
	output logic [15:0]	s_data,
	output logic [9:0]	tap_addr,
	output logic		en,
	output logic		m_ready,
	output logic		got,
	output logic [15:0]	word
);
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_valid <= 1'b0;
			s_data <= 16'h0000;
			tap_addr <= 10'h000;
			en <= 1'b1;
			m_ready <= 1'b0;
			got <= 1'b0;
		end else begin
			// An idle data line keeps changing so stale data is never read.
			if (!s_valid || (s_ready && en)) begin
				s_valid <= act && ($urandom % 4 != 0);
				s_data <= 16'($urandom);
			end
			en <= !act || ($urandom % 8 != 0);
			tap_addr <= 10'($urandom % tap_mod);
			m_ready <= !stall || ($urandom % 3 == 0);
			got <= m_valid && m_ready;
			word <= m_data;
		end
	end
endmodule // asr_stream_model

// ---- dv/addressable_shift_register_tb_top.sv ----
// Bench for asr_top: APB register checks and random stream traffic
// compared with a model of the shift chain.
// Assumes the stream model and the bound checker.
`timescale 1ns/100ps
module addressable_shift_register_tb_top;
	logic		clock = 1'b0;
	logic		rst_n = 1'b1;
	logic [7:0]	paddr = 8'h00;
	logic		psel = 1'b0;
	logic		penable = 1'b0;
	logic		pwrite = 1'b0;
	logic [31:0]	pwdata = 32'h0;
	logic		act = 1'b0;
	logic		stall = 1'b0;
	logic		cen = 1'b1;
	logic [10:0]	tap_mod = 11'h008;
	logic [15:0]	chain [1024];
	logic [15:0]	q [$];
	logic [15:0]	exp_w;
	logic [15:0]	last_w = 16'h0000;
	wire [31:0]	prdata;
	wire [15:0]	s_data, m_data, word;
	wire [9:0]	tap_addr;
	wire		pready, pslverr, s_valid, s_ready;
	wire		en, m_valid, m_ready, got;
	int		num_errors = 0;
	int		samples_checked = 0;
	int		takes = 0;
	int		dep = 1024;

	always #2.5 clock = ~clock;

	asr_top DUT (
		.clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.s_valid(s_valid), .s_ready(s_ready), .s_data(s_data),
		.tap_addr(tap_addr), .en(en), .m_valid(m_valid),
		.m_ready(m_ready), .m_data(m_data)
	);
	asr_stream_model u_far (
		.clock(clock), .rst_n(rst_n), .act(act), .stall(stall),
		.tap_mod(tap_mod), .s_ready(s_ready), .m_valid(m_valid),
		.m_data(m_data), .s_valid(s_valid), .s_data(s_data),
		.tap_addr(tap_addr), .en(en), .m_ready(m_ready),
		.got(got), .word(word)
	);

	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask

	task reload;
		for (int i = 0; i < 1024; i++)
			chain[i] = (i < 4) ? 16'(i + 1) : 16'h0000;
	endtask

	task apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
		input logic [31:0] ex, input logic ee);
		@(posedge clock);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave's answer.
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		if (!w)
			chk(prdata, ex);
		chk({31'h0, pslverr}, {31'h0, ee});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task run(input int c, input logic s, input logic [10:0] tm);
		int n;
		tap_mod <= tm;
		stall <= s;
		act <= 1'b1;
		repeat (c) @(posedge clock);
		act <= 1'b0;
		stall <= 1'b0;
		n = 0;
		repeat (4) @(posedge clock);
		// A sample still on offer is taken later and must land here, unless the input is closed.
		while ((q.size() != 0 || s_valid) && n < 200) begin
			@(posedge clock);
			n++;
		end
		chk(q.size(), 0);
	endtask

	always @(posedge clock) begin
		if (rst_n && got) begin
			exp_w = q.size() ? q.pop_front() : ~word;
			last_w = exp_w;
			chk(word, exp_w);
		end
		if (rst_n && s_valid && s_ready && en && cen) begin
			q.push_back(chain[tap_addr < dep ? tap_addr : dep - 1]);
			for (int i = 1023; i > 0; i--)
				chain[i] = chain[i - 1];
			chain[0] = s_data;
			takes++;
		end
	end

	task close_out;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		void'($urandom(16));
		reload();
		rst_n = 1'b0;
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		apb(8'h00, 1'b0, 32'h0, 32'h3, 1'b0);
		apb(8'h04, 1'b0, 32'h0, 32'h400, 1'b0);
		apb(8'h20, 1'b1, 32'h1, 32'h0, 1'b1);
		apb(8'h20, 1'b0, 32'h0, 32'h0, 1'b1);
		run(400, 1'b0, 11'h008);
		run(600, 1'b1, 11'h00C);
		apb(8'h00, 1'b1, 32'h2, 32'h0, 1'b0);
		cen <= 1'b0;
		run(100, 1'b1, 11'h008);
		// Reload while the input is closed, so no take meets the reload.
		apb(8'h00, 1'b1, 32'hE, 32'h0, 1'b0);
		reload();
		apb(8'h00, 1'b1, 32'h7, 32'h0, 1'b0);
		cen <= 1'b1;
		run(400, 1'b1, 11'h008);
		apb(8'h04, 1'b1, 32'h1, 32'h0, 1'b0);
		apb(8'h04, 1'b0, 32'h0, 32'h2, 1'b0);
		apb(8'h04, 1'b1, 32'h5, 32'h0, 1'b0);
		apb(8'h00, 1'b1, 32'h1, 32'h0, 1'b0);
		dep = 5;
		run(400, 1'b1, 11'h010);
		apb(8'h0C, 1'b0, 32'h0, takes, 1'b0);
		apb(8'h08, 1'b0, 32'h0, 32'h2, 1'b0);
		apb(8'h10, 1'b0, 32'h0, {16'h0000, last_w}, 1'b0);
		close_out();
	end

	initial begin
		#100000;
		num_errors++;
		close_out();
	end
endmodule // addressable_shift_register_tb_top
